// ===== core/wsil_pkg.sv
// wsil_pkg: constants and carrier types for the wake/status/interrupt block.
// assumes a 100 MHz digital clock and a host on the 4-wire serial link.
//
// Notes on behaviour
// - interrupt on key flag change, or wake/aux flag becoming set.
// - status read clears wake flag, supply-low flag, aux flag, interrupt.
// - key flag reads inverted key pin level.
// - wake flag marks wake-pin rise; while set, force supply and clock enables.
// - supply-low sets when supply drops; clears after recovery plus status read.
// - aux pin rise with voltage margin sets aux flag; interrupt only on 0-to-1.
// - wake pin rise sets wake flag after a delay; interrupt only on 0-to-1.
// - in OFF, key held low long enough wakes: reset low, supplies on.
// - after key wake and settle, set that key flag and interrupt.
// - clock output after supply valid and settle; host reset high when settled.
// - key event restarts debounce; at 8195 periods update flags, interrupt, stop.
// - same key again stops counter; other key restarts it.
// - while debounce runs, force supply and clock enables high.
// - status read or interrupt-clear command clears the interrupt.
// - in OFF, wake pin held high long enough wakes, then sets wake flag.
// - wake pin going low never enters OFF.
// - in OFF, aux above lower threshold wakes; above upper enters AUX, sets flag.
// - serial traffic in bytes, MSB first, command byte then data bytes.
// - during command byte, shift out buffer byte count.
// - serial logic held in reset while chip select low.
// - buffer read streams successive bytes.
// - command type in top three bits, address in low five.
// - interrupt-clear command drives interrupt pin low.
package wsil_pkg;
    localparam logic [4:0] WSIL_ADDR_EVENT_STATUS = 5'h08;
    localparam int WSIL_BIT_KEY0 = 0;
    localparam int WSIL_BIT_WAKE = 5;
    localparam int WSIL_BIT_LOWSUP = 6;
    localparam int WSIL_BIT_AUX = 7;
    localparam logic [7:0] WSIL_STATUS_RESET = 8'h00;
    localparam logic [2:0] WSIL_CMD_RD_BUF = 3'h0;
    localparam logic [2:0] WSIL_CMD_WR_BUF = 3'h1;
    localparam logic [2:0] WSIL_CMD_RD_REG = 3'h2;
    localparam logic [2:0] WSIL_CMD_WR_REG = 3'h3;
    localparam logic [2:0] WSIL_CMD_OFF = 3'h4;
    localparam logic [2:0] WSIL_CMD_CLR_IRQ = 3'h5;
    localparam int WSIL_DEBOUNCE_PERIODS = 8195;
    localparam int WSIL_CLK_NS = 10;
    localparam int WSIL_DCLK_NS = 10;
    localparam int WSIL_DEBOUNCE_CYC = WSIL_DEBOUNCE_PERIODS * WSIL_DCLK_NS / WSIL_CLK_NS;
    localparam int WSIL_KEY_WAKE_NS = 1000;
    localparam int WSIL_KEY_WAKE_CYC = (WSIL_KEY_WAKE_NS + WSIL_CLK_NS - 1) / WSIL_CLK_NS;
    localparam int WSIL_WAKE_MIN_NS = 1000;
    localparam int WSIL_WAKE_MIN_CYC = (WSIL_WAKE_MIN_NS + WSIL_CLK_NS - 1) / WSIL_CLK_NS;
    localparam int WSIL_WAKE_DELAY_NS = 200;
    localparam int WSIL_WAKE_DELAY_CYC = (WSIL_WAKE_DELAY_NS + WSIL_CLK_NS - 1) / WSIL_CLK_NS;
    localparam int WSIL_SETTLE_NS = 2000;
    localparam int WSIL_SETTLE_CYC = (WSIL_SETTLE_NS + WSIL_CLK_NS - 1) / WSIL_CLK_NS;

    typedef enum logic [1:0] {WSIL_OFF, WSIL_WAKING, WSIL_ACTIVE, WSIL_AUX} wsil_mode_t;
    typedef enum logic [1:0] {WSIL_SP_CMD, WSIL_SP_DATA, WSIL_SP_IGNORE} wsil_sp_t;

    // analog comparator results, all asynchronous to mclk
    typedef struct packed {
        logic supply_low;
        logic supply_ok;
        logic aux_low_thr;
        logic aux_high_thr;
        logic aux_margin;
        logic dsupply_ok;
        logic osc_settled;
    } wsil_analog_t;

    typedef struct packed {
        logic ext_supply_enable;
        logic clock_out_enable;
        logic host_reset_n;
        logic supplies_on;
    } wsil_power_t;
endpackage

// ===== core/wsil_top.sv
// wsil_top: status register, key debounce, wake/aux/supply-low flags, interrupt and serial front end.
// assumes the host serial clock is slow (80 ns) against mclk and all pins are asynchronous.
`timescale 1ns/1ps
module wsil_top #(
    parameter int KEYS = 5,
    parameter int DEBOUNCE_CYC = wsil_pkg::WSIL_DEBOUNCE_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [KEYS-1:0] key_input_pin,
    input wire logic wake_request_pin,
    input wire logic aux_supply_pin,
    input wire wsil_pkg::wsil_analog_t analog_in,
    input wire logic cs,
    input wire logic sck,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic [7:0] buf_count,
    input wire logic [7:0] buf_rd_data,
    output logic buf_rd_pulse,
    input wire logic [7:0] ctrl_rd_data,
    output logic [4:0] reg_addr,
    output logic [7:0] ctrl_wr_data,
    output logic ctrl_wr_pulse,
    output logic off_cmd_pulse,
    output logic irq,
    output wsil_pkg::wsil_power_t power_out,
    output wsil_pkg::wsil_mode_t mode
);
    import wsil_pkg::*;

    if (KEYS != 5 || DEBOUNCE_CYC < 2) begin : g_bad_params
        $error("wsil_top: unsupported parameters");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = KEYS + 3 + 7 + 3;
    // reset to the idle pin levels so that no false wake or serial edge follows reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{KEYS{1'b1}}, {(NSYNC - KEYS){1'b0}}};
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign raw_in = {key_input_pin, wake_request_pin, aux_supply_pin, 1'b0, analog_in,
                     cs, sck, serial_data_in};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic [KEYS-1:0] key_s;
    logic wake_s;
    logic aux_s;
    wsil_analog_t an_s;
    logic cs_s;
    logic sck_s;
    logic sdi_s;
    assign key_s = sync2_reg[NSYNC-1 -: KEYS];
    assign wake_s = sync2_reg[12];
    assign aux_s = sync2_reg[11];
    assign an_s = sync2_reg[9:3];
    assign cs_s = sync2_reg[2];
    assign sck_s = sync2_reg[1];
    assign sdi_s = sync2_reg[0];

    // ------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------
    logic sck_d_reg;
    wsil_sp_t sp_reg, sp_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] sh_in_reg, sh_in_next;
    logic [7:0] sh_out_reg, sh_out_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [4:0] addr_reg, addr_next;
    logic sdo_reg, sdo_next;
    logic sdo_oe_reg, sdo_oe_next;
    logic buf_rd_reg, buf_rd_next;
    logic wr_reg, wr_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic off_reg, off_next;
    logic status_read;
    logic clr_cmd;
    logic [7:0] status_reg;
    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_s & ~sck_d_reg;
    assign sck_fall = ~sck_s & sck_d_reg;

    always_comb begin
        sp_next = sp_reg;
        bit_next = bit_reg;
        sh_in_next = sh_in_reg;
        sh_out_next = sh_out_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        sdo_next = sdo_reg;
        sdo_oe_next = cs_s;
        buf_rd_next = 1'b0;
        wr_next = 1'b0;
        wr_data_next = wr_data_reg;
        off_next = 1'b0;
        status_read = 1'b0;
        clr_cmd = 1'b0;
        if (!cs_s) begin
            // held idle while deselected
            sp_next = WSIL_SP_CMD;
            bit_next = 3'h0;
            sh_out_next = {buf_count[6:0], 1'b0}; // msb already on the pin
            sdo_next = buf_count[7];
        end else begin
            if (sck_rise) begin
                sh_in_next = {sh_in_reg[6:0], sdi_s}; // msb first
                bit_next = bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    unique case (sp_reg)
                        WSIL_SP_CMD: begin
                            cmd_next = {sh_in_reg[6:0], sdi_s};
                            addr_next = sh_in_next[4:0];
                            unique case (sh_in_next[7:5])
                                WSIL_CMD_RD_BUF: begin
                                    sp_next = WSIL_SP_DATA;
                                    sh_out_next = buf_rd_data;
                                    buf_rd_next = 1'b1;
                                end
                                WSIL_CMD_RD_REG: begin
                                    sp_next = WSIL_SP_DATA;
                                    sh_out_next = (sh_in_next[4:0] == WSIL_ADDR_EVENT_STATUS) ?
                                                  status_reg : ctrl_rd_data;
                                    status_read = (sh_in_next[4:0] == WSIL_ADDR_EVENT_STATUS);
                                end
                                WSIL_CMD_WR_BUF, WSIL_CMD_WR_REG: begin
                                    sp_next = WSIL_SP_DATA;
                                    sh_out_next = sh_in_next; // echo
                                end
                                WSIL_CMD_OFF: begin
                                    off_next = 1'b1;
                                    sp_next = WSIL_SP_IGNORE;
                                end
                                WSIL_CMD_CLR_IRQ: begin
                                    clr_cmd = 1'b1;
                                    sp_next = WSIL_SP_IGNORE;
                                end
                                default: sp_next = WSIL_SP_IGNORE;
                            endcase
                        end
                        WSIL_SP_DATA: begin
                            unique case (cmd_reg[7:5])
                                WSIL_CMD_RD_BUF: begin
                                    sh_out_next = buf_rd_data; // next byte in sequence
                                    buf_rd_next = 1'b1;
                                end
                                WSIL_CMD_RD_REG: begin
                                    addr_next = addr_reg + 5'h01;
                                    sh_out_next = ctrl_rd_data;
                                end
                                WSIL_CMD_WR_REG: begin
                                    wr_next = 1'b1;
                                    wr_data_next = sh_in_next;
                                    addr_next = addr_reg + 5'h01;
                                    sh_out_next = sh_in_next;
                                end
                                default: sh_out_next = sh_in_next;
                            endcase
                        end
                        default: sp_next = WSIL_SP_IGNORE;
                    endcase
                end
            end
            if (sck_fall) begin
                sdo_next = sh_out_reg[7];
                sh_out_next = {sh_out_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sck_d_reg <= 1'b0;
            sp_reg <= WSIL_SP_CMD;
            bit_reg <= 3'h0;
            sh_in_reg <= 8'h00;
            sh_out_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 5'h00;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            off_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            sp_reg <= sp_next;
            bit_reg <= bit_next;
            sh_in_reg <= sh_in_next;
            sh_out_reg <= sh_out_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            sdo_reg <= sdo_next;
            sdo_oe_reg <= sdo_oe_next;
            buf_rd_reg <= buf_rd_next;
            wr_reg <= wr_next;
            wr_data_reg <= wr_data_next;
            off_reg <= off_next;
        end
    end

    // ------------------------------------------------------------
    // power modes, key debounce, flags, interrupt
    // ------------------------------------------------------------
    localparam int CW = $clog2(DEBOUNCE_CYC + 1);
    wsil_mode_t mode_reg, mode_next;
    logic [KEYS-1:0] key_d_reg;
    logic [KEYS-1:0] flags_reg, flags_next;
    logic wake_flag_reg, wake_flag_next;
    logic low_flag_reg, low_flag_next;
    logic aux_flag_reg, aux_flag_next;
    logic irq_reg, irq_next;
    logic wake_d_reg;
    logic aux_d_reg;
    logic run_reg, run_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [2:0] key_idx_reg, key_idx_next;
    logic [15:0] hold_reg, hold_next;
    logic [15:0] tmr_reg, tmr_next;
    logic wake_pend_reg, wake_pend_next;
    logic [KEYS-1:0] key_ev;
    logic [2:0] ev_idx;
    logic ready;
    assign key_ev = key_s ^ key_d_reg;
    assign ready = an_s.dsupply_ok & an_s.osc_settled;
    always_comb begin
        ev_idx = 3'h0;
        for (int i = KEYS - 1; i >= 0; i--) begin
            if (key_ev[i]) ev_idx = 3'(i);
        end
    end
    assign status_reg = {aux_flag_reg, low_flag_reg, wake_flag_reg, flags_reg};

    always_comb begin
        mode_next = mode_reg;
        flags_next = flags_reg;
        wake_flag_next = wake_flag_reg;
        low_flag_next = low_flag_reg;
        aux_flag_next = aux_flag_reg;
        irq_next = irq_reg;
        run_next = run_reg;
        cnt_next = cnt_reg;
        key_idx_next = key_idx_reg;
        hold_next = hold_reg;
        tmr_next = tmr_reg;
        wake_pend_next = wake_pend_reg;
        // clears first so that a same-cycle event below wins
        if (status_read) begin
            wake_flag_next = 1'b0;
            aux_flag_next = 1'b0;
            irq_next = 1'b0;
            if (!an_s.supply_low) low_flag_next = 1'b0;
        end
        if (clr_cmd) irq_next = 1'b0;
        if (an_s.supply_low && mode_reg != WSIL_OFF) low_flag_next = 1'b1;
        unique case (mode_reg)
            WSIL_OFF: begin
                // qualify hold time of a low key or high wake pin
                if (~&key_s || wake_s) hold_next = hold_reg + 16'h0001;
                else hold_next = 16'h0000;
                if (an_s.aux_low_thr) begin
                    mode_next = WSIL_WAKING;
                end else if (~&key_s && hold_reg >= 16'(WSIL_KEY_WAKE_CYC)) begin
                    mode_next = WSIL_WAKING;
                end else if (wake_s && hold_reg >= 16'(WSIL_WAKE_MIN_CYC)) begin
                    mode_next = WSIL_WAKING;
                end
            end
            WSIL_WAKING: begin
                if (ready) begin
                    mode_next = an_s.aux_high_thr ? WSIL_AUX : WSIL_ACTIVE;
                    flags_next = ~key_s;
                    if (~&key_s) irq_next = 1'b1;
                    if (wake_s) begin
                        wake_flag_next = 1'b1;
                        irq_next = 1'b1;
                    end
                    if (an_s.aux_high_thr) begin
                        aux_flag_next = 1'b1;
                        irq_next = 1'b1;
                    end
                end
            end
            default: begin
                // off only by command; a low wake pin has no effect here
                if (off_reg && !wake_s && &key_s) mode_next = WSIL_OFF;
                if (|key_ev) begin
                    if (run_reg && key_ev[key_idx_reg]) begin
                        run_next = 1'b0;
                    end else begin
                        run_next = 1'b1;
                        cnt_next = '0;
                        key_idx_next = ev_idx;
                    end
                end else if (run_reg) begin
                    if (cnt_reg == CW'(DEBOUNCE_CYC - 1)) begin
                        run_next = 1'b0;
                        if (flags_next != ~key_s) irq_next = 1'b1;
                        flags_next = ~key_s;
                    end else begin
                        cnt_next = cnt_reg + CW'(1);
                    end
                end
                if (wake_s && !wake_d_reg) begin
                    wake_pend_next = 1'b1;
                    tmr_next = 16'h0000;
                end else if (wake_pend_reg) begin
                    tmr_next = tmr_reg + 16'h0001;
                    if (tmr_reg >= 16'(WSIL_WAKE_DELAY_CYC - 1)) begin
                        wake_pend_next = 1'b0;
                        if (!wake_flag_next) irq_next = 1'b1;
                        wake_flag_next = 1'b1;
                    end
                end
                if (aux_s && !aux_d_reg && an_s.aux_margin) begin
                    if (!aux_flag_next) irq_next = 1'b1;
                    aux_flag_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= WSIL_OFF;
            key_d_reg <= '1;
            flags_reg <= WSIL_STATUS_RESET[KEYS-1:0];
            wake_flag_reg <= 1'b0;
            low_flag_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_d_reg <= 1'b1;
            aux_d_reg <= 1'b1;
            run_reg <= 1'b0;
            cnt_reg <= '0;
            key_idx_reg <= 3'h0;
            hold_reg <= 16'h0000;
            tmr_reg <= 16'h0000;
            wake_pend_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            key_d_reg <= key_s;
            flags_reg <= flags_next;
            wake_flag_reg <= wake_flag_next;
            low_flag_reg <= low_flag_next;
            aux_flag_reg <= aux_flag_next;
            irq_reg <= irq_next; // level until acknowledged
            wake_d_reg <= wake_s;
            aux_d_reg <= aux_s;
            run_reg <= run_next;
            cnt_reg <= cnt_next;
            key_idx_reg <= key_idx_next;
            hold_reg <= hold_next;
            tmr_reg <= tmr_next;
            wake_pend_reg <= wake_pend_next;
        end
    end

    // ------------------------------------------------------------
    // supply, clock output and host reset sequencing
    // ------------------------------------------------------------
    wsil_power_t pwr_reg, pwr_next;
    logic [15:0] settle_reg, settle_next;
    always_comb begin
        pwr_next = '0;
        settle_next = 16'h0000;
        if (mode_reg != WSIL_OFF) begin
            pwr_next.supplies_on = 1'b1;
            pwr_next.ext_supply_enable = 1'b1;
            settle_next = settle_reg;
            if (an_s.supply_ok && an_s.osc_settled && settle_reg < 16'(WSIL_SETTLE_CYC))
                settle_next = settle_reg + 16'h0001;
            // clock after supply valid and start-up time, or while the wake flag or the debounce forces it
            pwr_next.clock_out_enable = an_s.supply_ok && settle_reg >= 16'(WSIL_SETTLE_CYC);
            pwr_next.host_reset_n = an_s.supply_ok && an_s.osc_settled && mode_reg != WSIL_WAKING;
            if (wake_flag_reg || run_reg) begin
                pwr_next.ext_supply_enable = 1'b1;
                pwr_next.clock_out_enable = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pwr_reg <= '0;
            settle_reg <= 16'h0000;
        end else begin
            pwr_reg <= pwr_next;
            settle_reg <= settle_next;
        end
    end

    assign serial_data_out = sdo_reg;
    assign serial_data_out_oe = sdo_oe_reg;
    assign buf_rd_pulse = buf_rd_reg;
    assign reg_addr = addr_reg;
    assign ctrl_wr_data = wr_data_reg;
    assign ctrl_wr_pulse = wr_reg;
    assign off_cmd_pulse = off_reg;
    assign irq = irq_reg;
    assign power_out = pwr_reg;
    assign mode = mode_reg;
endmodule // wsil_top

// ===== sim/wsil_top_asserts.sv
// wsil_asserts: temporal checks on the ports of wsil_top, bound after the module.
// assumes one mclk domain with rstn asynchronous and active low.
`timescale 1ns/1ps
module wsil_asserts #(
    parameter int KEYS = 5
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [KEYS-1:0] key_input_pin,
    input wire logic wake_request_pin,
    input wire logic aux_supply_pin,
    input wire wsil_pkg::wsil_analog_t analog_in,
    input wire logic cs,
    input wire logic serial_data_out_oe,
    input wire logic irq,
    input wire wsil_pkg::wsil_power_t power_out,
    input wire wsil_pkg::wsil_mode_t mode
);
    import wsil_pkg::*;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // a bounce within 8 cycles stops the count, so only a quiet key must force
    sequence key_settle;
        mode == WSIL_ACTIVE && $changed(key_input_pin) ##1 $stable(key_input_pin) [*7];
    endsequence
    sequence forced_on;
        power_out.ext_supply_enable && power_out.clock_out_enable;
    endsequence
    sequence aux_rise;
        mode == WSIL_ACTIVE && $rose(aux_supply_pin) && analog_in.aux_margin;
    endsequence
    a_idle_no_drive: assert property ((!cs) [*4] |-> !serial_data_out_oe)
        else $error("serial output driven while deselected");
    a_irq_level_held: assert property (irq && !serial_data_out_oe |=> irq)
        else $error("irq dropped outside a transfer");
    a_key_forces_on: assert property (key_settle |-> forced_on)
        else $error("enables not forced while debouncing");
    a_quiet_debounce: assert property ($changed(key_input_pin) && !irq |=> (!irq) [*8])
        else $error("irq before debounce count");
    a_wake_low_stays: assert property ($fell(wake_request_pin) && mode != WSIL_OFF |=> (mode != WSIL_OFF) [*6])
        else $error("wake pin low entered off");
    a_reset_settled: assert property ($rose(power_out.host_reset_n) |-> analog_in.supply_ok && analog_in.osc_settled)
        else $error("host reset released before settle");
    a_waking_in_rst: assert property (mode == WSIL_WAKING |-> !power_out.host_reset_n)
        else $error("host reset high while waking");
    a_aux_raises_irq: assert property (aux_rise |-> ##[1:12] irq)
        else $error("aux rise gave no irq");
endmodule // wsil_asserts
bind wsil_top wsil_asserts #(.KEYS(KEYS)) u_chk (.*);

// ===== sim/wsil_host.sv
// wsil_host: behavioural host on the 4-wire serial link, 80 ns bit time.
// assumes the bench calls xfer and pops captured bytes from rx_q.
`timescale 1ns/1ps
module wsil_host (
    output logic cs,
    output logic sck,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [7:0] rx_q[$];
    initial begin
        cs = 1'b0;
        sck = 1'b0;
        serial_data_in = 1'b0;
    end
    // ----------------------------------------
    // one frame: command byte, then n filler bytes
    // ----------------------------------------
    task automatic xfer(input logic [7:0] cmd, input int n);
        logic [7:0] sh;
        sh = 8'h00;
        cs = 1'b1;
        #200;
        for (int b = 0; b <= n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                serial_data_in = (b == 0) ? cmd[i] : 1'b0;
                #40 sck = 1'b1;
                #30 sh = {sh[6:0], serial_data_out};
                #10 sck = 1'b0;
            end
            rx_q.push_back(sh);
        end
        // clock parks low and data toggles, so a stale bit cannot pass
        #100 cs = 1'b0;
        serial_data_in = ~serial_data_in;
        #200;
    endtask
endmodule // wsil_host

// ===== sim/tb_wake_status_irq_logic.sv
// tb_wake_status_irq_logic: self-checking bench for wsil_top with a serial host.
// assumes analog comparator results are driven as plain levels.
`timescale 1ns/1ps
module tb_wake_status_irq_logic;
    import wsil_pkg::*;
    // short debounce so each key case takes tens of cycles
    localparam int DEB = 16;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] key_input_pin = 5'h1F;
    logic wake_request_pin = 1'b0;
    logic aux_supply_pin = 1'b0;
    wsil_analog_t analog_in = 7'h23;
    logic [7:0] buf_count = 8'h00;
    logic cs, sck, serial_data_in, serial_data_out, serial_data_out_oe, irq;
    wsil_power_t power_out;
    wsil_mode_t mode;
    logic [15:0] rnd = 16'h22AE;
    logic m_wake = 1'b0, m_low = 1'b0, m_aux = 1'b0;
    logic [4:0] m_keys = 5'h00;
    int n_fail = 0;
    int tests_run = 0;
    always #5 mclk = ~mclk;
    wsil_top #(.DEBOUNCE_CYC(DEB)) u_dut (.*, .buf_rd_data(8'h5A), .ctrl_rd_data(8'hC3), .buf_rd_pulse(),
        .reg_addr(), .ctrl_wr_data(), .ctrl_wr_pulse(), .off_cmd_pulse());
    wsil_host u_host (.*);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_irq(input logic e, input int n);
        repeat (n) if (irq !== e) @(negedge mclk);
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic cmd(input logic [7:0] c, input int n);
        @(negedge mclk);
        rnd = lfsr(rnd);
        buf_count = rnd[7:0];
        // bytes of an earlier frame must not be taken for this one
        u_host.rx_q.delete();
        u_host.xfer(c, n);
    endtask
    task automatic rd_status();
        cmd({WSIL_CMD_RD_REG, WSIL_ADDR_EVENT_STATUS}, 1);
        chk("count", buf_count, u_host.rx_q.pop_front());
        chk("status", {m_aux, m_low, m_wake, m_keys}, u_host.rx_q.pop_front());
        m_wake = 1'b0;
        m_aux = 1'b0;
        if (!analog_in.supply_low) m_low = 1'b0;
        chk("irq read", 8'h00, {7'h0, irq});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        wake_request_pin = 1'b1;
        m_wake = 1'b1;
        repeat (150) @(negedge mclk);
        wake_request_pin = 1'b0;
        wait_irq(1'b1, 600);
        chk("host reset", 8'h01, {7'h0, power_out.host_reset_n});
        chk("mode", {6'h0, WSIL_ACTIVE}, {6'h0, mode});
        rd_status();
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            rnd = lfsr(rnd);
            key_input_pin = i[0] ? 5'h1F : ~(5'h01 << (rnd % 5));
            m_keys = ~key_input_pin;
            repeat (8) @(negedge mclk);
            chk("irq early", 8'h00, {7'h0, irq});
            wait_irq(1'b1, 60);
            cmd({WSIL_CMD_CLR_IRQ, 5'h00}, 0);
            chk("irq clear", 8'h00, {7'h0, irq});
            rd_status();
        end
        @(negedge mclk);
        key_input_pin = 5'h1E;
        repeat (6) @(negedge mclk);
        key_input_pin = 5'h1F;
        repeat (60) @(negedge mclk);
        chk("irq bounce", 8'h00, {7'h0, irq});
        rd_status();
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk);
            wake_request_pin = 1'b1;
            m_wake = 1'b1;
            repeat (60) @(negedge mclk);
            chk("irq wake", {7'h0, i == 0}, {7'h0, irq});
            chk("forced", 8'h03, {6'h0, power_out.ext_supply_enable, power_out.clock_out_enable});
            wake_request_pin = 1'b0;
            cmd({WSIL_CMD_CLR_IRQ, 5'h00}, 0);
        end
        rd_status();
        @(negedge mclk);
        analog_in.aux_margin = 1'b1;
        aux_supply_pin = 1'b1;
        m_aux = 1'b1;
        wait_irq(1'b1, 40);
        rd_status();
        aux_supply_pin = 1'b0;
        analog_in.supply_low = 1'b1;
        m_low = 1'b1;
        repeat (10) @(negedge mclk);
        rd_status();
        analog_in.supply_low = 1'b0;
        repeat (10) @(negedge mclk);
        rd_status();
        rd_status();
        cmd({WSIL_CMD_RD_BUF, 5'h00}, 2);
        chk("buf count", buf_count, u_host.rx_q.pop_front());
        repeat (2) chk("buf data", 8'h5A, u_host.rx_q.pop_front());
        results();
    end
    initial begin
        #300000;
        n_fail++;
        results();
    end
endmodule // tb_wake_status_irq_logic
